// File: isq_capture_model.sv
// Behavioural model of the logic capturing the buffered word stream.
// Assumes a word passes at a rising edge where valid and ready are both high.
`timescale 1ns/1ps
module isq_capture_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Stream from the sequencer
	input wire isq_pkg::isq_word_type stream_word,
	input wire logic stream_valid,
	output logic stream_ready = 1'b0,
	// Bench control and observed transfers
	input wire logic stall,
	output logic got_valid,
	output isq_pkg::isq_word_type got_word
);
	int seed = 39;

	// ==========================================================
	// Ready drops at random as well as on command, so the buffer sees short and long stalls.
	always @(posedge core_clk) begin
		stream_ready <= rst_n && !stall && (($random(seed) & 3) != 0);
	end
	// The word on offer is taken at the next edge when both are high.
	assign got_valid = stream_valid && stream_ready;
	assign got_word = stream_word;
endmodule

// File: isq_chk.sv
// Port assertions for the interleaved SAR sequencer.
// Assumes a bind into the sequencer top; it sees only that module's ports.
`timescale 1ns/1ps
module isq_chk #(
	parameter int CAL_CYCLES = 10000
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Observed pins
	input wire logic output_enable_n,
	input wire logic [15:0] input_switch,
	input wire logic [15:0] zero_switch,
	input wire logic [15:0] autocal_switch,
	input wire logic [15:0][7:0] offset_trim,
	input wire logic [15:0][7:0] gain_trim,
	input wire logic [9:0] sample_code_bits,
	input wire logic overrange_flag,
	input wire logic sample_code_oe,
	input wire logic overrange_oe,
	input wire logic cal_done
);
	logic [15:0] cyc_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// Cycles since release; it saturates so a long run cannot wrap it.
	always_ff @(posedge core_clk) begin
		if (!rst_n) cyc_r <= 16'h0000;
		else if (cyc_r != 16'hffff) cyc_r <= cyc_r + 16'h0001;
	end

	// ==========================================================
	// Switches are still zero in the first cycle after release, hence the past guard.
	a_one_sampler:
		assert property ($past(rst_n) |-> $onehot(input_switch)) else $error("sampler not one-hot");
	a_sample_rotates:
		assert property ($past(rst_n) |=> input_switch == {$past(input_switch[14:0]),
			$past(input_switch[15])}) else $error("sampling rotation broken");
	a_zero_leads:
		assert property ($past(rst_n) && zero_switch != 16'h0000 |-> ##3
			input_switch == $past(zero_switch, 3)) else $error("zero step not three before sample");
	a_autocal_leads:
		assert property ($past(rst_n) && autocal_switch != 16'h0000 |=>
			input_switch == $past(autocal_switch)) else $error("autocal step not before sample");
	a_ovr_forces:
		assert property (overrange_flag |-> sample_code_bits == 10'h3ff) else $error("code not forced");
	a_oe_off:
		assert property (output_enable_n [*7] |-> !sample_code_oe && !overrange_oe)
			else $error("pins driven while disabled");
	a_oe_on:
		assert property (!output_enable_n [*7] |-> sample_code_oe && overrange_oe)
			else $error("pins floating while enabled");
	a_cal_early:
		assert property (cyc_r + 2 < CAL_CYCLES |-> !cal_done) else $error("calibration done too early");
	a_cal_late:
		assert property (cyc_r == CAL_CYCLES + 3 |-> cal_done) else $error("calibration never done");
	a_cal_holds:
		assert property (cal_done |=> cal_done) else $error("calibration lapsed");
	// A trim may only step by one unit, which is below one output code.
	for (genvar s = 0; s < 16; s++) begin : g_trim
		a_trim_step:
			assert property ($past(rst_n) |->
				(offset_trim[s] - $past(offset_trim[s])) inside {8'h00, 8'h01, 8'hff} &&
				(gain_trim[s] - $past(gain_trim[s])) inside {8'h00, 8'h01, 8'hff})
				else $error("trim step too large");
	end
endmodule

// File: isq_pkg.sv
// Shared constants and carrier types for the interleaved SAR sequencer.
// Assumes one rising-edge core clock and a synchronous active-low reset.
package isq_pkg;

	// ==========================================================
	// Geometry
	localparam int SECTIONS = 16;
	localparam int PH_W = 4;
	localparam int RAW_W = 11;
	localparam int CODE_W = 10;
	localparam int LATENCY = 12;

	// ==========================================================
	// Per-section schedule steps, zero based.
	localparam logic [PH_W-1:0] STEP_ZERO = 4'h0;
	localparam logic [PH_W-1:0] STEP_AZ = 4'h1;
	localparam logic [PH_W-1:0] STEP_AC = 4'h2;
	localparam logic [PH_W-1:0] STEP_SAMPLE = 4'h3;
	localparam logic [PH_W-1:0] STEP_SAR_FIRST = 4'h4;
	localparam logic [PH_W-1:0] STEP_SAR_LAST = 4'he;
	localparam logic [PH_W-1:0] STEP_XFER = 4'hf;
	localparam logic [PH_W-1:0] PH_ONE = 4'h1;
	localparam logic [RAW_W-1:0] SAR_START = 11'h400;

	// ==========================================================
	// Calibration loops; trim unit is a fraction of an output LSB.
	localparam int TRIM_W = 8;
	localparam int ACC_W = 4;
	localparam logic signed [ACC_W-1:0] ACC_ZERO = 4'sh0;
	localparam logic signed [ACC_W-1:0] ACC_ONE = 4'sh1;
	localparam logic signed [ACC_W-1:0] ACC_LIMIT = 4'sh4;
	localparam logic signed [ACC_W-1:0] ACC_NEG_LIMIT = 4'shc;
	localparam logic signed [TRIM_W-1:0] TRIM_ZERO = 8'sh00;
	localparam logic signed [TRIM_W-1:0] TRIM_ONE = 8'sh01;
	localparam logic signed [TRIM_W-1:0] TRIM_MAX = 8'sh7f;
	localparam logic signed [TRIM_W-1:0] TRIM_MIN = 8'sh80;
	localparam int CAL_CYCLES_MIN = 10000;
	localparam int CAL_CNT_W = 14;
	localparam int PRIME_CYCLES = 16;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic ovr;
		logic [CODE_W-1:0] code;
	} isq_word_type;

	typedef struct packed {
		logic signed [ACC_W-1:0] acc;
		logic signed [TRIM_W-1:0] trim;
	} isq_cal_type;

endpackage

// File: isq_sequencer.sv
// Digital sequencer of a sixteen-way interleaved SAR converter plus its output FIFO.
// Assumes the analog sections return one comparator decision each per clock and
// follow the switch and trial-code outputs within the same cycle.
`timescale 1ns/1ps

// ==============================================================
// Output FIFO with a registered read stage
module isq_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
	localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
	localparam logic [AW-1:0] PTR_ONE = AW'(1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	// Full is honest: count reaches depth and the fill side sees ready drop.
	assign in_ready = (count_r != CNT_FULL);
	assign push = in_valid && in_ready;
	assign pop = (count_r != '0) && (!out_valid || out_ready);

	// Storage array write.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + PTR_ONE;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + PTR_ONE;
			end
			if (push && !pop) begin
				count_r <= count_r + CNT_ONE;
			end else if (pop && !push) begin
				count_r <= count_r - CNT_ONE;
			end
		end
	end

	// Read stage keeps the drain outputs straight from flops.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data <= mem[rd_ptr_r];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule

// ==============================================================
// Sequencer top
module isq_sequencer #(
	parameter int CAL_CYCLES = isq_pkg::CAL_CYCLES_MIN,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Output enable pin, active low
	input wire logic output_enable_n,
	// Comparator decisions, one per section
	input wire logic [isq_pkg::SECTIONS-1:0] comp_dec,
	// Section control towards the analog array
	output logic [isq_pkg::SECTIONS-1:0] input_switch,
	output logic [isq_pkg::SECTIONS-1:0] zero_switch,
	output logic [isq_pkg::SECTIONS-1:0] autocal_switch,
	output logic [isq_pkg::SECTIONS-1:0][isq_pkg::RAW_W-1:0] dac_trial,
	output logic [isq_pkg::SECTIONS-1:0][isq_pkg::TRIM_W-1:0] offset_trim,
	output logic [isq_pkg::SECTIONS-1:0][isq_pkg::TRIM_W-1:0] gain_trim,
	// Parallel output pins with their drive enables
	output logic [isq_pkg::CODE_W-1:0] sample_code_bits,
	output logic sample_code_oe,
	output logic overrange_flag,
	output logic overrange_oe,
	output logic data_valid,
	output logic cal_done,
	// Buffered capture stream
	output isq_pkg::isq_word_type stream_word,
	output logic stream_valid,
	input wire logic stream_ready,
	output logic buf_ready
);
	localparam logic [isq_pkg::CAL_CNT_W-1:0] CAL_LAST = isq_pkg::CAL_CNT_W'(CAL_CYCLES - 1);
	localparam logic [isq_pkg::CAL_CNT_W-1:0] PRIME_LAST =
		isq_pkg::CAL_CNT_W'(isq_pkg::PRIME_CYCLES - 1);
	localparam logic [isq_pkg::CAL_CNT_W-1:0] CNT_ONE = isq_pkg::CAL_CNT_W'(1);

	// Schedule step of one section for a given phase.
	function automatic logic [isq_pkg::PH_W-1:0] isq_step(
		input logic [isq_pkg::PH_W-1:0] ph,
		input int s
	);
		return ph - isq_pkg::PH_W'(s);
	endfunction

	// One SAR decision: keep or drop the bit under trial, then try the next one.
	function automatic logic [isq_pkg::RAW_W-1:0] isq_sar_next(
		input logic [isq_pkg::RAW_W-1:0] sar,
		input logic [isq_pkg::PH_W-1:0] step,
		input logic keep
	);
		logic [isq_pkg::RAW_W-1:0] nxt;
		int b;
		nxt = sar;
		b = isq_pkg::RAW_W - 1 - int'(step - isq_pkg::STEP_SAR_FIRST);
		if (!keep) begin
			nxt[b] = 1'b0;
		end
		if (b > 0) begin
			nxt[b-1] = 1'b1;
		end
		return nxt;
	endfunction

	// Up/down integrator that moves the trim one fractional unit at a time.
	function automatic isq_pkg::isq_cal_type isq_cal_step(
		input isq_pkg::isq_cal_type cur,
		input logic up
	);
		isq_pkg::isq_cal_type nxt;
		nxt = cur;
		nxt.acc = up ? cur.acc + isq_pkg::ACC_ONE : cur.acc - isq_pkg::ACC_ONE;
		if (nxt.acc == isq_pkg::ACC_LIMIT) begin
			nxt.acc = isq_pkg::ACC_ZERO;
			if (cur.trim != isq_pkg::TRIM_MIN) begin
				nxt.trim = cur.trim - isq_pkg::TRIM_ONE;
			end
		end else if (nxt.acc == isq_pkg::ACC_NEG_LIMIT) begin
			nxt.acc = isq_pkg::ACC_ZERO;
			if (cur.trim != isq_pkg::TRIM_MAX) begin
				nxt.trim = cur.trim + isq_pkg::TRIM_ONE;
			end
		end
		return nxt;
	endfunction

	logic [isq_pkg::PH_W-1:0] ph_r;
	logic [isq_pkg::PH_W-1:0] ph_nxt;
	logic [isq_pkg::RAW_W-1:0] sar_r [isq_pkg::SECTIONS];
	isq_pkg::isq_cal_type ofs_r [isq_pkg::SECTIONS];
	isq_pkg::isq_cal_type gain_r [isq_pkg::SECTIONS];
	logic [isq_pkg::CAL_CNT_W-1:0] run_cnt_r;
	logic en_n_s1_r;
	logic en_n_s2_r;
	logic en_n_s3_r;
	logic en_n_r;
	logic [isq_pkg::PH_W-1:0] done_sel;
	isq_pkg::isq_word_type word_nxt;
	logic fifo_in_ready;

	// ==========================================================
	// Sixteen-phase generator; wrapping at sixteen restarts the rotation.
	assign ph_nxt = ph_r + isq_pkg::PH_ONE;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ph_r <= '0;
		end else begin
			ph_r <= ph_nxt;
		end
	end

	// ==========================================================
	// Switch strobes are computed from the next phase so they hold during the step.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			input_switch <= '0;
			zero_switch <= '0;
			autocal_switch <= '0;
		end else begin
			for (int s = 0; s < isq_pkg::SECTIONS; s++) begin
				input_switch[s] <= (isq_step(ph_nxt, s) == isq_pkg::STEP_SAMPLE);
				zero_switch[s] <= (isq_step(ph_nxt, s) == isq_pkg::STEP_ZERO);
				autocal_switch[s] <= (isq_step(ph_nxt, s) == isq_pkg::STEP_AC);
			end
		end
	end

	// ==========================================================
	// Per-section work: calibration compares, sampling and the eleven SAR cycles.
	// The trims advance only on clock edges, so a stopped clock freezes them.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int s = 0; s < isq_pkg::SECTIONS; s++) begin
				sar_r[s] <= '0;
				ofs_r[s] <= '{acc: isq_pkg::ACC_ZERO, trim: isq_pkg::TRIM_ZERO};
				gain_r[s] <= '{acc: isq_pkg::ACC_ZERO, trim: isq_pkg::TRIM_ZERO};
			end
		end else begin
			for (int s = 0; s < isq_pkg::SECTIONS; s++) begin
				case (isq_step(ph_r, s))
					isq_pkg::STEP_AZ: begin
						ofs_r[s] <= isq_cal_step(ofs_r[s], comp_dec[s]);
					end
					isq_pkg::STEP_AC: begin
						gain_r[s] <= isq_cal_step(gain_r[s], comp_dec[s]);
					end
					isq_pkg::STEP_SAMPLE: begin
						sar_r[s] <= isq_pkg::SAR_START;
					end
					isq_pkg::STEP_ZERO, isq_pkg::STEP_XFER: begin
						sar_r[s] <= sar_r[s];
					end
					default: begin
						sar_r[s] <= isq_sar_next(sar_r[s], isq_step(ph_r, s), comp_dec[s]);
					end
				endcase
			end
		end
	end

	// Trial codes and trims leave straight from the section flops.
	always_comb begin
		for (int s = 0; s < isq_pkg::SECTIONS; s++) begin
			dac_trial[s] = sar_r[s];
			offset_trim[s] = ofs_r[s].trim;
			gain_trim[s] = gain_r[s].trim;
		end
	end

	// ==========================================================
	// Output mux picks the section finishing its last bit; the word is then on the
	// pins during that section's transfer step, twelve cycles after its sample.
	assign done_sel = ph_r - isq_pkg::STEP_SAR_LAST;

	always_comb begin
		logic [isq_pkg::RAW_W-1:0] raw;
		raw = isq_sar_next(sar_r[done_sel], isq_pkg::STEP_SAR_LAST, comp_dec[done_sel]);
		word_nxt.ovr = raw[isq_pkg::RAW_W-1];
		word_nxt.code = raw[isq_pkg::RAW_W-1] ? '1 : raw[isq_pkg::CODE_W-1:0];
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sample_code_bits <= '0;
			overrange_flag <= 1'b0;
		end else begin
			sample_code_bits <= word_nxt.code;
			overrange_flag <= word_nxt.ovr;
		end
	end

	// ==========================================================
	// Enable pin: three flops, a change is taken once the last two agree.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			en_n_s1_r <= 1'b1;
			en_n_s2_r <= 1'b1;
			en_n_s3_r <= 1'b1;
			en_n_r <= 1'b1;
		end else begin
			en_n_s1_r <= output_enable_n;
			en_n_s2_r <= en_n_s1_r;
			en_n_s3_r <= en_n_s2_r;
			if (en_n_s2_r == en_n_s3_r) begin
				en_n_r <= en_n_s3_r;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sample_code_oe <= 1'b0;
			overrange_oe <= 1'b0;
		end else begin
			sample_code_oe <= !en_n_r;
			overrange_oe <= !en_n_r;
		end
	end

	// ==========================================================
	// Run counter gives data valid once the pipe is primed and calibration done
	// after the minimum count; it saturates so it never wraps back.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			run_cnt_r <= '0;
			data_valid <= 1'b0;
			cal_done <= 1'b0;
		end else begin
			if (run_cnt_r != CAL_LAST) begin
				run_cnt_r <= run_cnt_r + CNT_ONE;
			end
			if (run_cnt_r == PRIME_LAST) begin
				data_valid <= 1'b1;
			end
			if (run_cnt_r == CAL_LAST) begin
				cal_done <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Capture stream; the converter cannot stall, so a full buffer drops words
	// and the registered ready tells the capture side it fell behind.
	isq_fifo #(
		.WIDTH($bits(isq_pkg::isq_word_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(core_clk),
		.rst_n(rst_n),
		.in_valid(data_valid),
		.in_data({overrange_flag, sample_code_bits}),
		.in_ready(fifo_in_ready),
		.out_valid(stream_valid),
		.out_data(stream_word),
		.out_ready(stream_ready)
	);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			buf_ready <= 1'b0;
		end else begin
			buf_ready <= fifo_in_ready;
		end
	end
endmodule

// File: tb_top.sv
// Self-checking bench for the interleaved SAR sequencer and its capture stream.
// Assumes the sequencer, checker and capture model are compiled before it.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %0t got %h want %h", $time, g, e); end end
module tb_top;
	localparam int CAL = 40;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic output_enable_n = 1'b0;
	logic stall = 1'b0;
	logic [15:0] comp_dec = 16'h0000;
	logic stream_ready, got_valid, cal_done, data_valid, buf_ready, stream_valid;
	logic sample_code_oe, overrange_oe, overrange_flag;
	logic [9:0] sample_code_bits;
	logic [15:0][7:0] offset_trim, gain_trim;
	logic [15:0][10:0] dac_trial;
	isq_pkg::isq_word_type stream_word, got_word;
	isq_pkg::isq_word_type expq[$];
	logic [10:0] tgt [16];
	logic [15:0] known = 16'h0000;
	logic [3:0] ph = 4'h0;
	int cyc = 0;
	int ticks = 0;
	int seed = 39;
	int n_mismatch = 0;
	int num_checks = 0;

	// ==========================================================
	// The clock never stops; a stopped clock would freeze the trims along with every other flop.
	initial forever #12.5 core_clk = ~core_clk;

	isq_sequencer #(.CAL_CYCLES(CAL), .FIFO_DEPTH(16)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .output_enable_n(output_enable_n),
		.comp_dec(comp_dec), .input_switch(), .zero_switch(), .autocal_switch(),
		.dac_trial(dac_trial), .offset_trim(offset_trim), .gain_trim(gain_trim),
		.sample_code_bits(sample_code_bits), .sample_code_oe(sample_code_oe),
		.overrange_flag(overrange_flag), .overrange_oe(overrange_oe),
		.data_valid(data_valid), .cal_done(cal_done), .stream_word(stream_word),
		.stream_valid(stream_valid), .stream_ready(stream_ready), .buf_ready(buf_ready));
	isq_capture_model cap_u (.core_clk(core_clk), .rst_n(rst_n), .stream_word(stream_word),
		.stream_valid(stream_valid), .stream_ready(stream_ready), .stall(stall),
		.got_valid(got_valid), .got_word(got_word));

	// ==========================================================
	// Expected pin word for one raw result.
	function automatic isq_pkg::isq_word_type want(input logic [10:0] raw);
		want.ovr = raw[10];
		want.code = raw[10] ? 10'h3ff : raw[9:0];
	endfunction
	// Target result for a sample; the edges of the range are mixed in on purpose.
	function automatic logic [10:0] pick(input logic [31:0] r);
		case (r[14:12])
			3'h0: pick = 11'h000;
			3'h1: pick = 11'h7ff;
			3'h2: pick = 11'h400;
			3'h3: pick = 11'h3ff;
			default: pick = r[10:0];
		endcase
	endfunction

	// Stands in for the analog array: SAR decisions steer each section to its target,
	// calibration decisions lean one way early and then alternate so the trims settle.
	// The lean gives each section five votes (six for the offset of section 15 and the gain of
	// section 14), so one trim step and one or two leftover counts; alternating votes then never reach the next step.
	always @(posedge core_clk) begin
		logic [3:0] nph;
		logic [3:0] st;
		nph = rst_n ? ph + 4'h1 : 4'h0;
		ph <= nph;
		cyc <= rst_n ? cyc + 1 : 0;
		ticks <= ticks + 1;
		for (int s = 0; s < 16; s++) begin
			st = nph - 4'(s);
			if (st == 4'h3) begin
				tgt[s] <= pick($random(seed));
				known[s] <= rst_n;
			end
			if (st >= 4'h4 && st <= 4'he) comp_dec[s] <= tgt[s][4'he - st];
			else if (st == 4'h1 || st == 4'h2) comp_dec[s] <= cyc < 80 ? !s[0] : cyc[4];
			else comp_dec[s] <= 1'($random(seed));
		end
		if (!rst_n) known <= 16'h0000;
		if (ticks > 3000) begin
			n_mismatch++;
			conclude();
		end
	end

	// Pins carry each section's word in its transfer step; the stream must deliver
	// them in order, though a full buffer may drop some.
	always @(negedge core_clk) begin
		if (!rst_n) expq.delete();
		else begin
			if (known[ph + 4'h1]) begin
				`CHK({overrange_flag, sample_code_bits}, want(tgt[ph + 4'h1]))
				`CHK(dac_trial[ph + 4'h1], tgt[ph + 4'h1])
				if (data_valid) expq.push_back(want(tgt[ph + 4'h1]));
			end
			// The section one step past its sample holds the mid-scale trial code.
			if (known[ph - 4'h4]) begin
				`CHK(dac_trial[ph - 4'h4], 11'h400)
			end
			if (got_valid) begin
				while (expq.size() > 0 && expq[0] !== got_word) void'(expq.pop_front());
				`CHK(expq.size() > 0, 1'b1)
				if (expq.size() > 0) void'(expq.pop_front());
			end
		end
	end

	// ==========================================================
	// Main sequence: calibration, a long capture stall, the enable pin, a second reset.
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (CAL - 4) @(posedge core_clk);
		@(negedge core_clk);
		`CHK(cal_done, 1'b0)
		repeat (200) @(posedge core_clk);
		@(negedge core_clk);
		`CHK(cal_done, 1'b1)
		for (int s = 0; s < 16; s++) begin
			`CHK(offset_trim[s], s[0] ? 8'h01 : 8'hff)
			`CHK(gain_trim[s], s[0] ? 8'h01 : 8'hff)
		end
		@(posedge core_clk);
		stall <= 1'b1;
		repeat (40) @(posedge core_clk);
		@(negedge core_clk);
		`CHK({buf_ready, stream_valid}, 2'b01)
		@(posedge core_clk);
		stall <= 1'b0;
		repeat (30) @(posedge core_clk);
		output_enable_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		`CHK({sample_code_oe, overrange_oe}, 2'b00)
		@(posedge core_clk);
		output_enable_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		`CHK({sample_code_oe, overrange_oe}, 2'b11)
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (100) @(posedge core_clk);
		conclude();
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
endmodule

bind isq_sequencer isq_chk #(.CAL_CYCLES(CAL_CYCLES)) chk_u (.core_clk(core_clk),
	.rst_n(rst_n), .output_enable_n(output_enable_n), .input_switch(input_switch),
	.zero_switch(zero_switch), .autocal_switch(autocal_switch), .offset_trim(offset_trim),
	.gain_trim(gain_trim), .sample_code_bits(sample_code_bits),
	.overrange_flag(overrange_flag), .sample_code_oe(sample_code_oe),
	.overrange_oe(overrange_oe), .cal_done(cal_done));
